// *** src/i2c_interrupt_status_clear.sv ***
// Event flags, masks, thresholds and read-to-clear registers of the two-wire controller
`timescale 1ns/1ps
`default_nettype none
module i2c_interrupt_status_clear
    import evt_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 32
) (
    input wire logic sys_clk_in, // System clock, 50 MHz
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic link_clk_in, // Two-wire link clock
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB write
    input wire logic [ADDR_W-1:0] paddr_in, // APB byte address
    input wire logic [DATA_W-1:0] pwdata_in, // APB write data
    output logic [DATA_W-1:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error on unmapped address
    input wire logic enable_in, // Controller enable bit
    input wire logic [LEVEL_W-1:0] tx_level_in, // Transmit FIFO level
    input wire logic [LEVEL_W-1:0] rx_level_in, // Receive FIFO level
    input wire logic data_cmd_write_in, // Processor write of data/command register
    input wire logic data_cmd_read_in, // Processor read of data/command register
    input wire logic sbyte_cause_in, // Start-byte abort cause still present
    input wire logic master_active_in, // Master state machine busy, link clock
    input wire logic slave_active_in, // Slave state machine busy, link clock
    input wire logic start_seen_in, // START or repeated START, link pulse
    input wire logic stop_seen_in, // STOP, link pulse
    input wire logic broadcast_ack_in, // Broadcast call acknowledged, link pulse
    input wire logic send_nack_in, // Slave transmit byte not acknowledged, link pulse
    input wire logic abort_in, // Transmit abort, link pulse
    input wire logic [CAUSE_W-1:0] abort_cause_in, // Abort cause, held on link clock
    input wire logic read_request_in, // Remote master read of slave, link pulse
    input wire logic rx_byte_in, // Byte received from bus, link pulse
    output logic hold_scl_low_out, // Stretch clock line, link clock
    output logic tx_flush_out, // Hold transmit FIFO flushed, refuse writes
    output logic rx_flush_out, // Hold receive FIFO flushed
    output logic rx_discard_out, // Drop the byte just received
    output logic internal_enable_out, // Enable held until state machines idle
    output logic intr_out // Combined interrupt
);
    // ************************************************************
    // Configuration check
    // ************************************************************
    initial begin
        if (FIFO_DEPTH < 2 || FIFO_DEPTH > 32) begin
            $error("FIFO_DEPTH must be 2 to 32");
        end
    end

    localparam logic [LEVEL_W-1:0] DEPTH_LEVEL = LEVEL_W'(FIFO_DEPTH);
    localparam logic [TL_W-1:0] TL_MAX = TL_W'(FIFO_DEPTH - 1);

    // ************************************************************
    // Link clock side
    // ************************************************************
    logic [NUM_EVENTS-1:0] link_events;
    logic [NUM_EVENTS-1:0] sys_events;
    logic [CAUSE_W-1:0] link_cause;
    logic [1:0] active_sync;
    logic [CAUSE_W-1:0] cause_sync;
    logic read_request;

    assign link_events[E_START] = start_seen_in;
    assign link_events[E_STOP] = stop_seen_in;
    assign link_events[E_BROADCAST] = broadcast_ack_in;
    assign link_events[E_SEND_DONE] = send_nack_in;
    assign link_events[E_ABORT] = abort_in;
    assign link_events[E_RD_REQ] = read_request_in;
    assign link_events[E_RX_BYTE] = rx_byte_in;

    // Cause held until the next abort so the crossing sees it stable
    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_cause <= '0;
        end else if (abort_in) begin
            link_cause <= abort_cause_in;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_cross
            pulse_cross u_cross (
                .src_clk_in(link_clk_in),
                .dst_clk_in(sys_clk_in),
                .rst_n_in(rst_n_in),
                .pulse_in(link_events[gi]),
                .pulse_out(sys_events[gi])
            );
        end
    endgenerate

    level_sync #(.WIDTH(2)) u_active_sync (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .d_in({master_active_in, slave_active_in}),
        .q_out(active_sync)
    );

    // Cause is stable well before its event pulse leaves the crossing
    level_sync #(.WIDTH(CAUSE_W)) u_cause_sync (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(link_cause),
        .q_out(cause_sync)
    );

    level_sync #(.WIDTH(1)) u_hold_sync (
        .clk_in(link_clk_in),
        .rst_n_in(rst_n_in),
        .d_in(read_request),
        .q_out(hold_scl_low_out)
    );

    wire any_active = |active_sync;

    // ************************************************************
    // Register access decode
    // ************************************************************
    logic [NUM_FLAGS-1:0] raw_event_status;
    logic [NUM_FLAGS-1:0] event_mask;
    logic [TL_W-1:0] receive_level_threshold;
    logic [TL_W-1:0] transmit_level_threshold;
    logic [CAUSE_W-1:0] abort_cause_register;
    logic next_tx_aborted;
    logic [LEVEL_W-1:0] tx_entries;

    wire access = psel_in && penable_in && !pready_out;
    wire rd = access && !pwrite_in;
    wire wr = access && pwrite_in;
    wire clear_all_read = rd && paddr_in == CLEAR_ALL_EVENTS_ADDR;
    wire underflow_clear_read = rd && paddr_in == CLEAR_RECEIVE_UNDERFLOW_ADDR;
    wire rx_overflow_clear_read = rd && paddr_in == CLEAR_RECEIVE_OVERFLOW_ADDR;
    wire tx_overflow_clear_read = rd && paddr_in == CLEAR_TRANSMIT_OVERFLOW_ADDR;
    wire read_request_clear_read = rd && paddr_in == CLEAR_READ_REQUEST_ADDR;
    wire abort_clear_read = rd && paddr_in == CLEAR_TRANSMIT_ABORT_ADDR;
    wire send_done_clear_read = rd && paddr_in == CLEAR_SLAVE_SEND_DONE_ADDR;
    wire busy_clear_read = rd && paddr_in == CLEAR_BUS_BUSY_SEEN_ADDR;
    wire stop_clear_read = rd && paddr_in == CLEAR_STOP_SEEN_ADDR;
    wire start_clear_read = rd && paddr_in == CLEAR_START_SEEN_ADDR;
    wire broadcast_clear_read = rd && paddr_in == CLEAR_BROADCAST_SEEN_ADDR;

    // Threshold clamp to one less than the buffer depth
    function automatic logic [TL_W-1:0] clamp_tl(input logic [DATA_W-1:0] value);
        clamp_tl = (value > DATA_W'(TL_MAX)) ? TL_MAX : value[TL_W-1:0];
    endfunction

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            event_mask <= EVENT_MASK_RESET;
            receive_level_threshold <= THRESHOLD_RESET;
            transmit_level_threshold <= THRESHOLD_RESET;
        end else if (wr) begin
            if (paddr_in == EVENT_MASK_ADDR) begin
                event_mask <= pwdata_in[NUM_FLAGS-1:0];
            end
            if (paddr_in == RECEIVE_LEVEL_THRESHOLD_ADDR) begin
                receive_level_threshold <= clamp_tl(pwdata_in);
            end
            if (paddr_in == TRANSMIT_LEVEL_THRESHOLD_ADDR) begin
                transmit_level_threshold <= clamp_tl(pwdata_in);
            end
        end
    end

    // ************************************************************
    // Internal enable and FIFO control
    // ************************************************************
    wire internal_enable = internal_enable_out;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            internal_enable_out <= 1'b0;
        end else if (enable_in) begin
            internal_enable_out <= 1'b1;
        end else if (!any_active) begin
            internal_enable_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_flush_out <= 1'b1;
            rx_flush_out <= 1'b1;
        end else begin
            tx_flush_out <= !enable_in || next_tx_aborted;
            rx_flush_out <= !enable_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_discard_out <= 1'b0;
        end else begin
            rx_discard_out <= sys_events[E_RX_BYTE] && rx_level_in >= DEPTH_LEVEL;
        end
    end

    // ************************************************************
    // Sticky event flags and the two level flags
    // ************************************************************
    wire off = !internal_enable;

    // Set wins over every clear in the same cycle
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        sticky = set || (cur && !clr);
    endfunction

    always_comb begin
        next_tx_aborted = sticky(raw_event_status[B_TX_ABORT], sys_events[E_ABORT],
            abort_clear_read || clear_all_read || off);
    end

    assign read_request = raw_event_status[B_RD_REQ];

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            raw_event_status <= '0;
        end else begin
            raw_event_status[B_BROADCAST] <= sticky(raw_event_status[B_BROADCAST],
                sys_events[E_BROADCAST], broadcast_clear_read || clear_all_read || off);
            raw_event_status[B_START] <= sticky(raw_event_status[B_START],
                sys_events[E_START], start_clear_read || clear_all_read || off);
            raw_event_status[B_STOP] <= sticky(raw_event_status[B_STOP],
                sys_events[E_STOP], stop_clear_read || clear_all_read || off);
            raw_event_status[B_ACTIVITY] <= sticky(raw_event_status[B_ACTIVITY], any_active,
                ((busy_clear_read || clear_all_read) && !any_active)
                || (!enable_in && !any_active));
            raw_event_status[B_SEND_DONE] <= sticky(raw_event_status[B_SEND_DONE],
                sys_events[E_SEND_DONE], send_done_clear_read || clear_all_read || off);
            raw_event_status[B_TX_ABORT] <= next_tx_aborted;
            raw_event_status[B_RD_REQ] <= sticky(raw_event_status[B_RD_REQ],
                sys_events[E_RD_REQ], read_request_clear_read || clear_all_read || off);
            raw_event_status[B_TX_OVER] <= sticky(raw_event_status[B_TX_OVER],
                data_cmd_write_in && tx_level_in >= DEPTH_LEVEL,
                tx_overflow_clear_read || clear_all_read || off);
            raw_event_status[B_RX_OVER] <= sticky(raw_event_status[B_RX_OVER],
                sys_events[E_RX_BYTE] && rx_level_in >= DEPTH_LEVEL,
                rx_overflow_clear_read || clear_all_read || off);
            raw_event_status[B_RX_UNDER] <= sticky(raw_event_status[B_RX_UNDER],
                data_cmd_read_in && rx_level_in == '0,
                underflow_clear_read || clear_all_read || off);
            raw_event_status[B_TX_EMPTY] <= enable_in
                ? (LEVEL_W'(tx_level_in) <= tx_entries) : any_active;
            raw_event_status[B_RX_LEVEL] <= enable_in
                && (rx_level_in >= LEVEL_W'(receive_level_threshold) + LEVEL_W'(1));
        end
    end

    // Top threshold code stands for a full buffer
    always_comb begin
        tx_entries = (transmit_level_threshold == TL_MAX)
            ? DEPTH_LEVEL : LEVEL_W'(transmit_level_threshold);
    end

    // ************************************************************
    // Abort cause register
    // ************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            abort_cause_register <= '0;
        end else begin
            if (abort_clear_read || clear_all_read) begin
                abort_cause_register <= '0;
            end
            if (sys_events[E_ABORT]) begin
                abort_cause_register <= cause_sync;
            end
            if (sbyte_cause_in && abort_cause_register[B_SBYTE_CAUSE]) begin
                abort_cause_register[B_SBYTE_CAUSE] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Combined interrupt
    // ************************************************************
    wire [NUM_FLAGS-1:0] masked_status = raw_event_status & event_mask;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            intr_out <= 1'b0;
        end else begin
            intr_out <= |masked_status;
        end
    end

    // ************************************************************
    // Bus answer
    // ************************************************************
    logic [DATA_W-1:0] next_rdata;
    logic mapped;

    always_comb begin
        next_rdata = '0;
        mapped = 1'b1;
        case (paddr_in)
            MASKED_STATUS_ADDR: next_rdata = DATA_W'(masked_status);
            EVENT_MASK_ADDR: next_rdata = DATA_W'(event_mask);
            RAW_EVENT_STATUS_ADDR: next_rdata = DATA_W'(raw_event_status);
            RECEIVE_LEVEL_THRESHOLD_ADDR: next_rdata = DATA_W'(receive_level_threshold);
            TRANSMIT_LEVEL_THRESHOLD_ADDR: next_rdata = DATA_W'(transmit_level_threshold);
            CLEAR_BUS_BUSY_SEEN_ADDR: next_rdata = DATA_W'(raw_event_status[B_ACTIVITY]);
            ABORT_CAUSE_ADDR: next_rdata = abort_cause_register;
            CLEAR_ALL_EVENTS_ADDR, CLEAR_RECEIVE_UNDERFLOW_ADDR,
            CLEAR_RECEIVE_OVERFLOW_ADDR, CLEAR_TRANSMIT_OVERFLOW_ADDR,
            CLEAR_READ_REQUEST_ADDR, CLEAR_TRANSMIT_ABORT_ADDR,
            CLEAR_SLAVE_SEND_DONE_ADDR, CLEAR_STOP_SEEN_ADDR,
            CLEAR_START_SEEN_ADDR, CLEAR_BROADCAST_SEEN_ADDR: next_rdata = '0;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end else begin
            pready_out <= access;
            pslverr_out <= access && !mapped;
            prdata_out <= rd ? next_rdata : '0;
        end
    end
endmodule
`default_nettype wire

// *** src/evt_pkg.sv ***
// Shared constants of the two-wire event, mask and clear logic
package evt_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned LEVEL_W = 6;
    localparam int unsigned TL_W = 5;
    localparam int unsigned CAUSE_W = 16;
    localparam int unsigned NUM_EVENTS = 7;
    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [31:0] MASKED_STATUS_ADDR = 32'h5000132c;
    localparam logic [31:0] EVENT_MASK_ADDR = 32'h50001330;
    localparam logic [31:0] RAW_EVENT_STATUS_ADDR = 32'h50001334;
    localparam logic [31:0] RECEIVE_LEVEL_THRESHOLD_ADDR = 32'h50001338;
    localparam logic [31:0] TRANSMIT_LEVEL_THRESHOLD_ADDR = 32'h5000133c;
    localparam logic [31:0] CLEAR_ALL_EVENTS_ADDR = 32'h50001340;
    localparam logic [31:0] CLEAR_RECEIVE_UNDERFLOW_ADDR = 32'h50001344;
    localparam logic [31:0] CLEAR_RECEIVE_OVERFLOW_ADDR = 32'h50001348;
    localparam logic [31:0] CLEAR_TRANSMIT_OVERFLOW_ADDR = 32'h5000134c;
    localparam logic [31:0] CLEAR_READ_REQUEST_ADDR = 32'h50001350;
    localparam logic [31:0] CLEAR_TRANSMIT_ABORT_ADDR = 32'h50001354;
    localparam logic [31:0] CLEAR_SLAVE_SEND_DONE_ADDR = 32'h50001358;
    localparam logic [31:0] CLEAR_BUS_BUSY_SEEN_ADDR = 32'h5000135c;
    localparam logic [31:0] CLEAR_STOP_SEEN_ADDR = 32'h50001360;
    localparam logic [31:0] CLEAR_START_SEEN_ADDR = 32'h50001364;
    localparam logic [31:0] CLEAR_BROADCAST_SEEN_ADDR = 32'h50001368;
    localparam logic [31:0] ABORT_CAUSE_ADDR = 32'h50001380;
    // ************************************************************
    // Event bit positions and the start-byte abort cause bit
    // ************************************************************
    localparam int unsigned B_RX_UNDER = 0;
    localparam int unsigned B_RX_OVER = 1;
    localparam int unsigned B_RX_LEVEL = 2;
    localparam int unsigned B_TX_OVER = 3;
    localparam int unsigned B_TX_EMPTY = 4;
    localparam int unsigned B_RD_REQ = 5;
    localparam int unsigned B_TX_ABORT = 6;
    localparam int unsigned B_SEND_DONE = 7;
    localparam int unsigned B_ACTIVITY = 8;
    localparam int unsigned B_STOP = 9;
    localparam int unsigned B_START = 10;
    localparam int unsigned B_BROADCAST = 11;
    localparam int unsigned NUM_FLAGS = 12;
    localparam int unsigned B_SBYTE_CAUSE = 9;
    // Link event indices
    localparam int unsigned E_START = 0;
    localparam int unsigned E_STOP = 1;
    localparam int unsigned E_BROADCAST = 2;
    localparam int unsigned E_SEND_DONE = 3;
    localparam int unsigned E_ABORT = 4;
    localparam int unsigned E_RD_REQ = 5;
    localparam int unsigned E_RX_BYTE = 6;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [11:0] EVENT_MASK_RESET = 12'h8ff;
    localparam logic [4:0] THRESHOLD_RESET = 5'h00;
endpackage

// *** src/level_sync.sv ***
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_in, // Destination clock
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d_in, // Levels from another domain
    output logic [WIDTH-1:0] q_out // Synchronised levels
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("level_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

// *** src/pulse_cross.sv ***
// Toggle crossing of one-cycle events from the link clock to the system clock
`timescale 1ns/1ps
`default_nettype none
module pulse_cross (
    input wire logic src_clk_in, // Link clock
    input wire logic dst_clk_in, // System clock
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic pulse_in, // One-cycle event on the link clock
    output logic pulse_out // One-cycle event on the system clock
);
    logic toggle;
    logic meta;
    logic sync;
    logic sync_d;

    always_ff @(posedge src_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            toggle <= 1'b0;
        end else if (pulse_in) begin
            toggle <= ~toggle;
        end
    end

    always_ff @(posedge dst_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            meta <= toggle;
            sync <= meta;
            sync_d <= sync;
            pulse_out <= sync ^ sync_d;
        end
    end
endmodule
`default_nettype wire

// *** verif/i2c_interrupt_status_clear_props.sv ***
// Port checker for the event and clear block
`timescale 1ns/1ps
`default_nettype none
module i2c_interrupt_status_clear_props
    import evt_pkg::*;
(
    input wire logic sys_clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic psel_in, // Select
    input wire logic penable_in, // Access phase
    input wire logic enable_in, // Enable bit
    input wire logic [LEVEL_W-1:0] rx_level_in, // Rx level
    input wire logic [DATA_W-1:0] prdata_out, // Read data
    input wire logic pready_out, // Ready
    input wire logic pslverr_out, // Error
    input wire logic rx_discard_out, // Byte dropped
    input wire logic tx_flush_out, // Tx flushed
    input wire logic rx_flush_out, // Rx flushed
    input wire logic internal_enable_out // Held enable
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_take; psel_in && penable_in && !pready_out |=> pready_out; endproperty
    a_take: assert property (p_take) else $error("no ready");
    property p_pulse; pready_out |=> !pready_out; endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_idle; !pready_out |-> prdata_out == 16'h0 && !pslverr_out; endproperty
    a_idle: assert property (p_idle) else $error("stray data");
    property p_err; pslverr_out |-> pready_out && prdata_out == 16'h0; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_rxflush; 1'h1 |=> rx_flush_out != $past(enable_in); endproperty
    a_rxflush: assert property (p_rxflush) else $error("rx flush");
    property p_txflush; !enable_in |=> tx_flush_out; endproperty
    a_txflush: assert property (p_txflush) else $error("tx flush");
    property p_ien_on; enable_in |=> internal_enable_out; endproperty
    a_ien_on: assert property (p_ien_on) else $error("ien on");
    property p_ien_off; $fell(internal_enable_out) |-> !$past(enable_in); endproperty
    a_ien_off: assert property (p_ien_off) else $error("ien off");
    property p_discard; rx_discard_out |-> $past(rx_level_in) >= 6'h20; endproperty
    a_discard: assert property (p_discard) else $error("discard");
    c_err: cover property (pslverr_out);
    c_discard: cover property (rx_discard_out);
    c_ien_off: cover property ($fell(internal_enable_out));
endmodule
bind i2c_interrupt_status_clear i2c_interrupt_status_clear_props props (.sys_clk_in,
    .rst_n_in, .psel_in, .penable_in, .enable_in, .rx_level_in, .prdata_out, .pready_out,
    .pslverr_out, .rx_discard_out, .tx_flush_out, .rx_flush_out, .internal_enable_out);
`default_nettype wire

// *** verif/link_partner.sv ***
// Far-side bus parties as link-clock events
`timescale 1ns/1ps
`default_nettype none
module link_partner
    import evt_pkg::*;
(
    input wire logic link_clk_in, // Link clock
    output logic [NUM_EVENTS-1:0] event_out, // Events
    output logic [CAUSE_W-1:0] cause_out, // Abort cause
    output logic active_out // Busy
);
    initial begin
        event_out = '0;
        cause_out = 16'h0;
        active_out = 1'h0;
    end
    task automatic send(input int e, input logic [15:0] c);
        @(posedge link_clk_in);
        event_out[e] <= 1'h1;
        cause_out <= c;
        @(posedge link_clk_in);
        event_out <= '0;
        cause_out <= ~c;
    endtask
endmodule
`default_nettype wire

// *** verif/i2c_interrupt_status_clear_test.sv ***
// Self-checking bench of the event and clear block
`timescale 1ns/1ps
`default_nettype none
module i2c_interrupt_status_clear_test;
    import evt_pkg::*;
    logic sys_clk = 1'h0, link_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, enable = 1'h0, dc_wr = 1'h0, dc_rd = 1'h0, sbyte = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [15:0] pwdata = 16'h0, prdata, rd, cause;
    logic [5:0] tx_level = 6'h00, rx_level = 6'h00;
    logic [6:0] evt;
    logic pready, pslverr, hold, txf, rxf, disc, ien, intr, act, er;
    int n_errors = 0, compares = 0, cycles = 0;
    initial forever #10 sys_clk = ~sys_clk;
    initial #1.7 forever #3 link_clk = ~link_clk;
    link_partner lp (.link_clk_in(link_clk), .event_out(evt), .cause_out(cause), .active_out(act));
    i2c_interrupt_status_clear dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .link_clk_in(link_clk),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .enable_in(enable), .tx_level_in(tx_level), .rx_level_in(rx_level),
        .data_cmd_write_in(dc_wr), .data_cmd_read_in(dc_rd), .sbyte_cause_in(sbyte),
        .master_active_in(act), .slave_active_in(act), .start_seen_in(evt[E_START]),
        .stop_seen_in(evt[E_STOP]), .broadcast_ack_in(evt[E_BROADCAST]),
        .send_nack_in(evt[E_SEND_DONE]), .abort_in(evt[E_ABORT]), .abort_cause_in(cause),
        .read_request_in(evt[E_RD_REQ]), .rx_byte_in(evt[E_RX_BYTE]), .hold_scl_low_out(hold),
        .tx_flush_out(txf), .rx_flush_out(rxf), .rx_discard_out(disc),
        .internal_enable_out(ien), .intr_out(intr));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic acc(input logic wr, input logic [31:0] a, input logic [15:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        w(1);
        penable <= 1'h1;
        w(2);
        chk("ready", 16'h1, 16'(pready));
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        w(1);
    endtask
    task automatic rr(input logic [31:0] a);
        acc(1'h0, a, 16'h0);
    endtask
    task automatic bit_chk(input string n, input int b, input logic v);
        rr(RAW_EVENT_STATUS_ADDR);
        chk(n, 16'(v), 16'(rd[b]));
    endtask
    task automatic t_reset;
        rr(EVENT_MASK_ADDR);
        chk("mask", 16'h8ff, rd);
        rr(RAW_EVENT_STATUS_ADDR);
        chk("raw", 16'h0, rd);
        rr(32'h50001300);
        chk("unmapped", 16'h1, {rd[14:0], er});
    endtask
    task automatic t_events;
        int ev[5] = '{E_START, E_STOP, E_BROADCAST, E_SEND_DONE, E_RD_REQ};
        int bt[5] = '{B_START, B_STOP, B_BROADCAST, B_SEND_DONE, B_RD_REQ};
        logic [31:0] ca[5] = '{CLEAR_START_SEEN_ADDR, CLEAR_STOP_SEEN_ADDR,
            CLEAR_BROADCAST_SEEN_ADDR, CLEAR_SLAVE_SEND_DONE_ADDR, CLEAR_READ_REQUEST_ADDR};
        enable <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            lp.send(ev[i], 16'h0);
            w(10);
            bit_chk("set", bt[i], 1'h1);
            if (i == 4) begin
                chk("stretch", 16'h1, 16'(hold));
                dc_wr <= 1'h1;
                w(1);
                dc_wr <= 1'h0;
            end
            rr(ca[i]);
            bit_chk("clr", bt[i], 1'h0);
        end
        chk("unstretch", 16'h0, 16'(hold));
    endtask
    task automatic t_abort;
        sbyte <= 1'h1;
        lp.send(E_ABORT, 16'h208);
        w(10);
        bit_chk("abort", B_TX_ABORT, 1'h1);
        chk("flush", 16'h1, 16'(txf));
        rr(ABORT_CAUSE_ADDR);
        chk("cause", 16'h208, rd);
        rr(CLEAR_TRANSMIT_ABORT_ADDR);
        bit_chk("unabort", B_TX_ABORT, 1'h0);
        rr(ABORT_CAUSE_ADDR);
        chk("cause kept", 16'h200, rd);
        chk("unflush", 16'h0, 16'(txf));
        sbyte <= 1'h0;
    endtask
    task automatic t_over;
        tx_level <= 6'h20;
        dc_wr <= 1'h1;
        dc_rd <= 1'h1;
        w(1);
        dc_wr <= 1'h0;
        dc_rd <= 1'h0;
        rx_level <= 6'h20;
        w(2);
        lp.send(E_RX_BYTE, 16'h0);
        w(10);
        rr(RAW_EVENT_STATUS_ADDR);
        chk("over", 16'hf, rd & 16'h1f);
        rr(CLEAR_ALL_EVENTS_ADDR);
        rr(RAW_EVENT_STATUS_ADDR);
        chk("clr all", 16'h4, rd & 16'hf);
        acc(1'h1, EVENT_MASK_ADDR, 16'h4);
        rr(MASKED_STATUS_ADDR);
        chk("masked", 16'h4, rd);
        chk("intr", 16'h1, 16'(intr));
        acc(1'h1, EVENT_MASK_ADDR, 16'h0);
        chk("no intr", 16'h0, 16'(intr));
    endtask
    task automatic t_level;
        acc(1'h1, RECEIVE_LEVEL_THRESHOLD_ADDR, 16'h3);
        rx_level <= 6'h03;
        bit_chk("below", B_RX_LEVEL, 1'h0);
        rx_level <= 6'h04;
        bit_chk("at", B_RX_LEVEL, 1'h1);
        acc(1'h1, TRANSMIT_LEVEL_THRESHOLD_ADDR, 16'hffff);
        rr(TRANSMIT_LEVEL_THRESHOLD_ADDR);
        chk("clamp", 16'h1f, rd);
        bit_chk("tx32", B_TX_EMPTY, 1'h1);
        enable <= 1'h0;
        w(3);
        rr(RAW_EVENT_STATUS_ADDR);
        chk("off", 16'h0, rd & 16'h14);
        chk("flushes", 16'h3, {14'h0, txf, rxf});
        chk("ien", 16'h0, 16'(ien));
    endtask
    task automatic final_report;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report;
        end
    end
    initial begin
        w(2);
        rst_n <= 1'h1;
        w(1);
        t_reset;
        t_events;
        t_abort;
        t_over;
        t_level;
        final_report;
    end
endmodule
`default_nettype wire
